// [rtl/pid_pkg.sv]
// constants and register map of the protect/inhibit digital port
package pid_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DIO = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam logic [3:0] OFS_CLEAR = 4'hC;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    // control fields
    localparam int CTRL_MODE = 0;
    localparam int CTRL_INHIBIT_LO = 1;
    localparam int CTRL_FIE = 3;
    localparam int CTRL_SRC_LO = 4;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [2:0] DIO_RESET = 3'h7;
    // mode encodings
    localparam logic MODE_INHIBIT_FAULT = 1'b0;
    localparam logic MODE_THREE_BIT_IO = 1'b1;
    // remote inhibit setting encodings
    localparam logic [1:0] INHIBIT_OFF = 2'h0;
    localparam logic [1:0] INHIBIT_LIVE = 2'h1;
    localparam logic [1:0] INHIBIT_LATCHING = 2'h2;
    // fault source encodings
    localparam logic [1:0] SRC_SERVICE_REQ = 2'h0;
    localparam logic [1:0] SRC_EVENT_STAT = 2'h1;
    localparam logic [1:0] SRC_OPERATION = 2'h2;
    localparam logic [1:0] SRC_QUESTIONABLE = 2'h3;
    // status fields
    localparam int STAT_OUT_EN = 0;
    localparam int STAT_LATCHED = 1;
    localparam int STAT_INHIBIT_PIN = 2;
    localparam int STAT_FAULT = 3;
    localparam int STAT_PINS_LO = 4;
    // interrupt bits
    localparam int IRQ_INHIBIT = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_PIN_CHANGE = 2;
    // port pin roles in inhibit-and-fault mode
    localparam int PIN_FAULT = 0;
    localparam int PIN_INHIBIT = 2;
    // bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } pid_bus_t;
endpackage

// [rtl/pid_port.sv]
// protect/inhibit digital port with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module pid_port (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // internal status summaries
    input wire logic service_request_summary,
    input wire logic event_status_summary,
    input wire logic operation_status_summary,
    input wire logic questionable_status_summary,
    // port pins, open drain
    input wire logic [2:0] port_in,
    output logic [2:0] port_out,
    output logic [2:0] port_oe,
    // source output control and interrupt
    output logic source_output_enable,
    output logic irq
);
    logic [5:0] ctrl;
    logic [2:0] dio_value;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic inhibit_latched;
    logic fault_act;
    logic inhibit_prev;
    logic [2:0] pins_prev;
    pid_pkg::pid_bus_t bus_state;

    logic mode_io;
    logic [1:0] inhibit_set;
    logic fie;
    logic [1:0] src_sel;
    logic inhibit_input;
    logic inhibit_active;
    logic fault_now;
    logic bus_req;
    logic bus_go;
    logic wr_go;
    logic clear_hit;
    logic [31:0] rd_mux;
    logic [2:0] next_irq_stat;
    logic next_out_en;

    // pick one internal summary by select code
    function automatic logic pick_summary(input logic [1:0] sel,
                                          input logic [3:0] sums);
        unique case (sel)
            pid_pkg::SRC_SERVICE_REQ: pick_summary = sums[0];
            pid_pkg::SRC_EVENT_STAT: pick_summary = sums[1];
            pid_pkg::SRC_OPERATION: pick_summary = sums[2];
            pid_pkg::SRC_QUESTIONABLE: pick_summary = sums[3];
        endcase
    endfunction

    // byte offset compare, shared by every decode
    function automatic logic hit(input logic [4:0] addr,
                                 input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction

    // control field split
    assign mode_io = ctrl[pid_pkg::CTRL_MODE];
    assign inhibit_set = ctrl[pid_pkg::CTRL_INHIBIT_LO +: 2];
    assign fie = ctrl[pid_pkg::CTRL_FIE];
    assign src_sel = ctrl[pid_pkg::CTRL_SRC_LO +: 2];
    assign inhibit_input = port_in[pid_pkg::PIN_INHIBIT];

    // inhibit is asserted low, only in inhibit mode with setting on;
    // spare code 3 acts as off, so it raises no onset event either
    assign inhibit_active =
        (mode_io == pid_pkg::MODE_INHIBIT_FAULT) &&
        (inhibit_set == pid_pkg::INHIBIT_LIVE ||
         inhibit_set == pid_pkg::INHIBIT_LATCHING) &&
        !inhibit_input;

    // fault request from the selected summary
    assign fault_now = (mode_io == pid_pkg::MODE_INHIBIT_FAULT) &&
                       fie &&
                       pick_summary(src_sel,
                                    {questionable_status_summary,
                                     operation_status_summary,
                                     event_status_summary,
                                     service_request_summary});

    // bus decode; the access completes on the edge where wait is low
    assign bus_req = avs_read || avs_write;
    assign bus_go = bus_req && !avs_waitrequest;
    assign wr_go = bus_go && avs_write;
    assign clear_hit = wr_go && hit(avs_address, {1'b0, pid_pkg::OFS_CLEAR})
                       && avs_writedata[0];

    // read mux, unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(avs_address, {1'b0, pid_pkg::OFS_CTRL})) begin
            rd_mux[5:0] = ctrl;
        end else if (hit(avs_address, {1'b0, pid_pkg::OFS_DIO})) begin
            rd_mux[2:0] = mode_io ? port_in : dio_value;
        end else if (hit(avs_address, {1'b0, pid_pkg::OFS_STAT})) begin
            rd_mux[pid_pkg::STAT_OUT_EN] = source_output_enable;
            rd_mux[pid_pkg::STAT_LATCHED] = inhibit_latched;
            rd_mux[pid_pkg::STAT_INHIBIT_PIN] = inhibit_input;
            rd_mux[pid_pkg::STAT_FAULT] = fault_act;
            rd_mux[pid_pkg::STAT_PINS_LO +: 3] = port_in;
        end else if (hit(avs_address, pid_pkg::OFS_IRQ_STAT)) begin
            rd_mux[2:0] = irq_stat;
        end else if (hit(avs_address, pid_pkg::OFS_IRQ_MASK)) begin
            rd_mux[2:0] = irq_mask;
        end
    end

    // one wait cycle per access keeps read data registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state <= pid_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            unique case (bus_state)
                pid_pkg::BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state <= pid_pkg::BUS_DONE;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                pid_pkg::BUS_DONE: begin
                    bus_state <= pid_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state <= pid_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // host settings; reset puts the port in inhibit-and-fault mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= pid_pkg::CTRL_RESET;
            dio_value <= pid_pkg::DIO_RESET;
            irq_mask <= 3'h0;
        end else if (ce && wr_go) begin
            if (hit(avs_address, {1'b0, pid_pkg::OFS_CTRL})) begin
                ctrl <= avs_writedata[5:0];
            end
            if (hit(avs_address, {1'b0, pid_pkg::OFS_DIO})) begin
                dio_value <= avs_writedata[2:0];
            end
            if (hit(avs_address, pid_pkg::OFS_IRQ_MASK)) begin
                irq_mask <= avs_writedata[2:0];
            end
        end
    end

    // latch: set beats clear so a fresh inhibit is never lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inhibit_latched <= 1'b0;
        end else if (ce) begin
            if (inhibit_active &&
                inhibit_set == pid_pkg::INHIBIT_LATCHING) begin
                inhibit_latched <= 1'b1;
            end else if (clear_hit) begin
                inhibit_latched <= 1'b0;
            end
        end
    end

    // output enable; the latch only counts in inhibit mode
    always_comb begin
        next_out_en = 1'b1;
        if (mode_io == pid_pkg::MODE_INHIBIT_FAULT) begin
            if (inhibit_set == pid_pkg::INHIBIT_LIVE) begin
                next_out_en = !inhibit_active;
            end else if (inhibit_set == pid_pkg::INHIBIT_LATCHING) begin
                next_out_en = !inhibit_active && !inhibit_latched;
            end
        end
    end

    // registered outputs; fault is not latched, it follows the summary
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            source_output_enable <= 1'b1;
            fault_act <= 1'b0;
        end else if (ce) begin
            source_output_enable <= next_out_en;
            fault_act <= fault_now;
        end
    end

    // pins: open drain, a zero bit pulls low, a one releases high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_out <= 3'h0;
            port_oe <= 3'h0;
        end else if (ce) begin
            port_out <= 3'h0;
            if (mode_io == pid_pkg::MODE_THREE_BIT_IO) begin
                port_oe <= ~dio_value;
            end else begin
                port_oe <= 3'h0;
                port_oe[pid_pkg::PIN_FAULT] <= fault_now;
            end
        end
    end

    // event detection for interrupts
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_go && hit(avs_address, pid_pkg::OFS_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~avs_writedata[2:0];
        end
        // sets come after the clear so they win
        if (inhibit_active && !inhibit_prev) begin
            next_irq_stat[pid_pkg::IRQ_INHIBIT] = 1'b1;
        end
        if (fault_now && !fault_act) begin
            next_irq_stat[pid_pkg::IRQ_FAULT] = 1'b1;
        end
        if (mode_io && port_in != pins_prev) begin
            next_irq_stat[pid_pkg::IRQ_PIN_CHANGE] = 1'b1;
        end
    end

    // sticky status and level interrupt, edge history beside them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat <= 3'h0;
            irq <= 1'b0;
            inhibit_prev <= 1'b0;
            pins_prev <= 3'h0;
        end else if (ce) begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            inhibit_prev <= inhibit_active;
            pins_prev <= port_in;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reset_mode;
        $fell(rst) |-> mode_io == pid_pkg::MODE_INHIBIT_FAULT;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("port not in inhibit mode after reset");

    property p_mode_io_pins;
        ce && mode_io |=> port_oe == ~$past(dio_value);
    endproperty
    a_mode_io_pins: assert property (p_mode_io_pins)
        else $error("io mode pins do not follow value");

    property p_live_off;
        ce && inhibit_set == pid_pkg::INHIBIT_LIVE && !mode_io
            && !inhibit_input |=> !source_output_enable;
    endproperty
    a_live_off: assert property (p_live_off)
        else $error("inhibit low did not disable output");

    property p_live_on;
        ce && inhibit_set == pid_pkg::INHIBIT_LIVE && !mode_io
            && inhibit_input |=> source_output_enable;
    endproperty
    a_live_on: assert property (p_live_on)
        else $error("live output did not return");

    property p_latch_holds;
        ce && inhibit_latched && !clear_hit && !mode_io
            && inhibit_set == pid_pkg::INHIBIT_LATCHING
            |=> !source_output_enable && inhibit_latched;
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latched inhibit released output");

    property p_fault_gate;
        ce && !mode_io && !fie |=> port_oe == 3'h0;
    endproperty
    a_fault_gate: assert property (p_fault_gate)
        else $error("fault driven while disabled");

    property p_fault_follow;
        ce && !mode_io && fie && src_sel == pid_pkg::SRC_OPERATION
            |=> port_oe[pid_pkg::PIN_FAULT] == $past(operation_status_summary);
    endproperty
    a_fault_follow: assert property (p_fault_follow)
        else $error("fault does not follow selected summary");

    property p_latch_no_self_clear;
        ce && inhibit_latched && !clear_hit |=> inhibit_latched;
    endproperty
    a_latch_no_self_clear: assert property (p_latch_no_self_clear)
        else $error("latch cleared without host");

    property p_io_no_inhibit;
        ce && mode_io |=> source_output_enable;
    endproperty
    a_io_no_inhibit: assert property (p_io_no_inhibit)
        else $error("inhibit active in io mode");

    property p_bus_answer;
        bus_req && avs_waitrequest && ce |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus not answered in one cycle");

    c_latch_then_clear: cover property (inhibit_latched ##[1:20]
                                        !inhibit_latched);
    c_fault_seen: cover property (port_oe[pid_pkg::PIN_FAULT]);
    c_irq_seen: cover property (irq);
endmodule
`default_nettype wire

// [dv/pid_ext_model.sv]
// equipment wired to the port pins: pull-ups plus external drivers
`timescale 1ns/1ps
`default_nettype none
module pid_ext_model (
    // pins as driven by the port
    input wire logic [2:0] port_out,
    input wire logic [2:0] port_oe,
    // external drivers, 1 = pull the pin low
    input wire logic [2:0] ext_low,
    // resolved wire levels
    output logic [2:0] port_in
);
    // open drain wire: released pins float up through the pull-ups
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            port_in[i] = port_oe[i] ? port_out[i] : ~ext_low[i];
        end
    end
endmodule
`default_nettype wire

// [dv/pid_port_test.sv]
// self-checking bench of the protect/inhibit digital port
`timescale 1ns/1ps
`default_nettype none
module pid_port_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic wreq, sout, irq;
    logic [3:0] sums = 4'h0;
    logic [2:0] ext_low = 3'h0;
    logic [2:0] pin, pout, poe, v;
    logic [31:0] rnd = 32'hA783;
    logic [31:0] q_exp[$];
    logic [31:0] q_msk[$];
    int error_cnt = 0;
    int checked = 0;

    pid_port uut (.clk(clk), .rst(rst), .ce(ce), .avs_address(adr),
        .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wreq),
        .service_request_summary(sums[0]), .event_status_summary(sums[1]),
        .operation_status_summary(sums[2]),
        .questionable_status_summary(sums[3]), .port_in(pin),
        .port_out(pout), .port_oe(poe), .source_output_enable(sout),
        .irq(irq));
    pid_ext_model ext (.port_out(pout), .port_oe(poe), .ext_low(ext_low),
        .port_in(pin));

    // free-running 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [31:0] ctl(input logic m,
        input logic [1:0] isel, input logic fie, input logic [1:0] src);
        return {26'h0, src, fie, isel, m};
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got, exp, msk);
        checked++;
        if ((got & msk) !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [2:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus access; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        logic s;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr_s <= w;
        rd_s <= ~w;
        for (n = 0; n < 40; n++) begin
            #1 s = wreq;
            @(posedge clk);
            if (s === 1'b0) break;
        end
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        if (n == 40) begin
            error_cnt++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
        q_exp.push_back(e);
        q_msk.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask

    // drive the far side, then let outputs settle mid-cycle
    task automatic drive(input logic [2:0] e, input logic [3:0] s);
        @(posedge clk);
        ext_low <= e;
        sums <= s;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // read data is judged while waitrequest is low, oldest note first
    always @(negedge clk) begin
        if (rd_s === 1'b1 && wreq === 1'b0) begin
            if (q_exp.size() == 0) begin
                cmp_rd(rdata, 32'hFFFF_FFFF, 32'h0);
            end else begin
                cmp_rd(rdata, q_exp.pop_front(), q_msk.pop_front());
            end
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        drive(3'h0, 4'h0);
        chk({2'h0, sout}, 3'h1);
        chk(poe, 3'h0);
        rd(pid_pkg::OFS_CTRL, 32'h0, 32'h1);
        rd(pid_pkg::OFS_DIO, 32'h7, 32'h7);
        rd(pid_pkg::OFS_STAT, 32'h1, 32'h3);
        wr(5'h18, 32'h1);
        rd(5'h18, 32'h0, 32'hFFFF_FFFF);
        rd(pid_pkg::OFS_CTRL, 32'h0, 32'hFFFF_FFFF);
        $display("reset and map done");
        // inhibit off, then live tracking
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h1);
        wr(pid_pkg::OFS_CTRL, ctl(1'b0, pid_pkg::INHIBIT_LIVE, 1'b0, 2'h0));
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h0);
        drive(3'h0, 4'h0);
        chk({2'h0, sout}, 3'h1);
        // clock enable low freezes the output enable
        @(posedge clk);
        ce <= 1'b0;
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h1);
        @(posedge clk);
        ce <= 1'b1;
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h0);
        drive(3'h0, 4'h0);
        $display("live inhibit done");
        // latching inhibit, with interrupt raise, mask and clear
        wr(pid_pkg::OFS_IRQ_STAT, 32'h7);
        wr(pid_pkg::OFS_IRQ_MASK, 32'h1);
        // spare setting code 3 acts as off: no disable, no onset event
        wr(pid_pkg::OFS_CTRL, ctl(1'b0, 2'h3, 1'b0, 2'h0));
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h1);
        chk({2'h0, irq}, 3'h0);
        drive(3'h0, 4'h0);
        wr(pid_pkg::OFS_CTRL,
            ctl(1'b0, pid_pkg::INHIBIT_LATCHING, 1'b0, 2'h0));
        drive(3'h4, 4'h0);
        chk({2'h0, irq}, 3'h1);
        drive(3'h0, 4'h0);
        chk({2'h0, sout}, 3'h0);
        rd(pid_pkg::OFS_STAT, 32'h2, 32'h3);
        rd(pid_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        wr(pid_pkg::OFS_IRQ_MASK, 32'h0);
        drive(3'h0, 4'h0);
        chk({2'h0, irq}, 3'h0);
        wr(pid_pkg::OFS_IRQ_STAT, 32'h1);
        wr(pid_pkg::OFS_IRQ_MASK, 32'h1);
        drive(3'h0, 4'h0);
        chk({2'h0, irq}, 3'h0);
        chk({2'h0, sout}, 3'h0);
        wr(pid_pkg::OFS_CLEAR, 32'h1);
        drive(3'h0, 4'h0);
        chk({2'h0, sout}, 3'h1);
        $display("latching inhibit done");
        // every fault source, selected and unselected
        for (int i = 0; i < 4; i++) begin
            wr(pid_pkg::OFS_CTRL, ctl(1'b0, 2'h0, 1'b1, i[1:0]));
            drive(3'h0, 4'h1 << i);
            chk({2'h0, poe[0]}, 3'h1);
            chk({2'h0, pin[0]}, 3'h0);
            drive(3'h0, ~(4'h1 << i));
            chk({2'h0, poe[0]}, 3'h0);
        end
        wr(pid_pkg::OFS_CTRL, ctl(1'b0, 2'h0, 1'b0, 2'h3));
        drive(3'h0, 4'hF);
        chk(poe, 3'h0);
        rd(pid_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
        $display("fault output done");
        // three-bit io with inhibit and fault armed but ignored
        wr(pid_pkg::OFS_CTRL, ctl(1'b1, pid_pkg::INHIBIT_LIVE, 1'b1, 2'h0));
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            v = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : rnd[2:0];
            wr(pid_pkg::OFS_DIO, {29'h0, v});
            drive(3'h0, 4'hF);
            chk(poe, ~v);
            chk(pin, v);
            chk(pout, 3'h0);
            rd(pid_pkg::OFS_DIO, {29'h0, v}, 32'h7);
            drive(3'h4, 4'hF);
            chk({2'h0, sout}, 3'h1);
            rd(pid_pkg::OFS_DIO, {29'h0, v & 3'h3}, 32'h7);
        end
        rd(pid_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
        wr(pid_pkg::OFS_CTRL, ctl(1'b0, pid_pkg::INHIBIT_LIVE, 1'b0, 2'h0));
        drive(3'h4, 4'h0);
        chk({2'h0, sout}, 3'h0);
        $display("io mode done");
        finish_test();
    end
endmodule
`default_nettype wire
